// ===== clkgen_cfg_pkg.sv
// Purpose: Shared constants for the clock generator configuration bank.
// Assumes: Byte-wide registers at 16-bit byte addresses.
// Notes:   Reset values are plain defaults; none are documented for the bank.
package clkgen_cfg_pkg;

    // ==========================================================
    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ==========================================================
    // Register offsets
    localparam logic [15:0] FIXED_SEQ_ADDRESS_28  = 16'h0856;
    localparam logic [15:0] FIXED_SEQ_VALUE_28    = 16'h0858;
    localparam logic [15:0] FIXED_SEQ_ADDRESS_29  = 16'h0859;
    localparam logic [15:0] FIXED_SEQ_VALUE_29    = 16'h085B;
    localparam logic [15:0] FIXED_SEQ_ADDRESS_30  = 16'h085C;
    localparam logic [15:0] FIXED_SEQ_VALUE_30    = 16'h085E;
    localparam logic [15:0] FIXED_SEQ_ADDRESS_31  = 16'h085F;
    localparam logic [15:0] FIXED_SEQ_VALUE_31    = 16'h0861;
    localparam logic [15:0] FIXED_SEQ_BASE        = 16'h0856;
    localparam logic [15:0] FIXED_SEQ_LAST        = 16'h0861;
    localparam int          FIXED_SEQ_BYTES       = 12;
    localparam logic [15:0] REFERENCE_PIN_CONFIG  = 16'h090E;
    localparam logic [15:0] LOOP_MODE_SELECT      = 16'h091C;
    localparam logic [15:0] IO_LEVEL_CONFIG       = 16'h0943;
    localparam logic [15:0] INPUT_CLOCK_CONTROL   = 16'h0949;
    localparam logic [15:0] INPUT_ROUTING_ENABLE  = 16'h094A;
    localparam logic [15:0] FEEDBACK_RATIO_FLAG   = 16'h095E;
    localparam logic [15:0] DIVIDER_CLOCK_ENABLE  = 16'h0A03;
    localparam logic [15:0] DIVIDER_INTERP_BYPASS = 16'h0A04;

    // ==========================================================
    // Field positions
    localparam int REF_EXT_CLK_BIT  = 0;
    localparam int REF_POWER_BIT    = 1;
    localparam int LOOP_MODE_LSB    = 0;
    localparam int LOOP_MODE_W      = 3;
    localparam int IO_LEVEL_BIT     = 0;
    localparam int IN_EN_LSB        = 0;
    localparam int IN_EN_W          = 4;
    localparam int PULSED_LSB       = 4;
    localparam int ROUTE_LSB        = 4;
    localparam int ROUTE_W          = 3;
    localparam int DIV_W            = 4;

    // ==========================================================
    // Field codes
    localparam logic [2:0] LOOP_ZERO_DELAY = 3'h3;
    localparam logic [2:0] LOOP_NORMAL     = 3'h4;
    localparam logic       IO_LEVEL_1V8    = 1'h0;
    localparam logic       IO_LEVEL_3V3    = 1'h1;

    // ==========================================================
    // Reset values (plain defaults)
    localparam logic [7:0] REF_CFG_RESET    = 8'h02;
    localparam logic [7:0] LOOP_MODE_RESET  = 8'h04;
    localparam logic [7:0] IO_LEVEL_RESET   = 8'h00;
    localparam logic [7:0] IN_CTRL_RESET    = 8'h00;
    localparam logic [7:0] ROUTE_RESET      = 8'h00;
    localparam logic [7:0] RATIO_RESET      = 8'h00;
    localparam logic [7:0] DIV_EN_RESET     = 8'h00;
    localparam logic [7:0] DIV_BYP_RESET    = 8'h00;
    localparam logic [7:0] FIXED_SEQ_RESET  = 8'h00;

    // Decoded loop mode
    typedef enum logic [1:0] {
        LOOP_IS_NORMAL,
        LOOP_IS_ZERO_DELAY,
        LOOP_IS_ILLEGAL
    } loop_mode_t;

endpackage

// ===== cfg_byte_reg.sv
// Purpose: One byte-wide configuration register with a writable mask.
// Assumes: Same clock as the register port.
// Notes:   Bits outside the mask hold zero and read as zero.
module cfg_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Write port
    input  wire logic       writeStrobe,
    input  wire logic [7:0] writeData,
    // Stored value
    output logic      [7:0] value
);
    logic [7:0] next_value;

    // ==========================================================
    // Next value: take masked data on a write
    always_comb begin
        next_value = value;
        if (writeStrobe) begin
            next_value = writeData & WRITE_MASK;
        end
    end

    // Register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            value <= RESET_VALUE & WRITE_MASK;
        end else begin
            value <= next_value;
        end
    end
endmodule // cfg_byte_reg

// ===== clock_gen_input_divider_config.sv
// Purpose: Configuration bank for reference pins, loop mode, I/O level,
//          input clocks, input routing and output divider clocking.
// Assumes: A serial host front end delivers byte reads and writes on the
//          same clock; addresses are the documented register addresses.
// Notes:   Read data is registered and valid one cycle after the read.
module clock_gen_input_divider_config
    import clkgen_cfg_pkg::*;
#(
    parameter int NUM_DIVIDERS = 4
) (
    // Clock and reset
    clk,
    rstn,
    // Serial host register port
    regAddr,
    regWrite,
    regRead,
    regWriteData,
    regReadData,
    regReadValid,
    regHit,
    // Reference pins
    ref_pin_external_clock_select,
    ref_oscillator_power_on,
    // Loop mode
    loop_mode_field,
    zeroDelayMode,
    normalMode,
    loopModeIllegal,
    // I/O level
    ioLevel3v3,
    // Input clocks
    inputEnables,
    feedbackInputEnable,
    pulsed_single_ended_enables,
    input_to_phase_detector_enables,
    feedbackRatioInteger,
    // Output dividers
    dividerClockEnables,
    interpolator_bypass_bits,
    // Fixed sequence slots
    fixedSeqBytes
);
    import clkgen_cfg_pkg::*;

    // Clock and reset
    input  wire logic                              clk;
    input  wire logic                              rstn;
    // Serial host register port
    input  wire logic [clkgen_cfg_pkg::ADDR_W-1:0] regAddr;
    input  wire logic                              regWrite;
    input  wire logic                              regRead;
    input  wire logic [clkgen_cfg_pkg::DATA_W-1:0] regWriteData;
    output logic      [clkgen_cfg_pkg::DATA_W-1:0] regReadData;
    output logic                                   regReadValid;
    output logic                                   regHit;
    // Reference pins
    output logic                                   ref_pin_external_clock_select;
    output logic                                   ref_oscillator_power_on;
    // Loop mode
    output logic      [2:0]                        loop_mode_field;
    output logic                                   zeroDelayMode;
    output logic                                   normalMode;
    output logic                                   loopModeIllegal;
    // I/O level
    output logic                                   ioLevel3v3;
    // Input clocks
    output logic      [3:0]                        inputEnables;
    output logic                                   feedbackInputEnable;
    output logic      [3:0]                        pulsed_single_ended_enables;
    output logic      [2:0]                        input_to_phase_detector_enables;
    output logic                                   feedbackRatioInteger;
    // Output dividers
    output logic      [NUM_DIVIDERS-1:0]           dividerClockEnables;
    output logic      [NUM_DIVIDERS-1:0]           interpolator_bypass_bits;
    // Fixed sequence slots
    output logic      [8*FIXED_SEQ_BYTES-1:0]      fixedSeqBytes;

    localparam int NREG = 8;
    localparam logic [15:0] REG_ADDR [NREG] = '{
        REFERENCE_PIN_CONFIG, LOOP_MODE_SELECT, IO_LEVEL_CONFIG,
        INPUT_CLOCK_CONTROL, INPUT_ROUTING_ENABLE, FEEDBACK_RATIO_FLAG,
        DIVIDER_CLOCK_ENABLE, DIVIDER_INTERP_BYPASS};
    localparam logic [7:0] REG_RESET [NREG] = '{
        REF_CFG_RESET, LOOP_MODE_RESET, IO_LEVEL_RESET, IN_CTRL_RESET,
        ROUTE_RESET, RATIO_RESET, DIV_EN_RESET, DIV_BYP_RESET};
    localparam logic [7:0] REG_MASK [NREG] = '{
        8'h03, 8'h07, 8'h01, 8'hFF, 8'h70, 8'h01, 8'h0F, 8'h0F};

    logic [7:0]       regValue [NREG];
    logic [7:0]       seqValue [FIXED_SEQ_BYTES];
    logic [NREG-1:0]  regSelect;
    logic [FIXED_SEQ_BYTES-1:0] seqSelect;
    logic             seqHit;
    logic [15:0]      seqOffset;
    logic [7:0]       readMux;
    logic [7:0]       next_regReadData;
    logic             next_regReadValid;
    loop_mode_t       loopMode;

    // ==========================================================
    // Address decode
    always_comb begin
        seqHit    = (regAddr >= FIXED_SEQ_BASE) && (regAddr <= FIXED_SEQ_LAST);
        seqOffset = regAddr - FIXED_SEQ_BASE;
        for (int i = 0; i < NREG; i++) begin
            regSelect[i] = (regAddr == REG_ADDR[i]);
        end
        for (int j = 0; j < FIXED_SEQ_BYTES; j++) begin
            seqSelect[j] = seqHit && (seqOffset == 16'(j));
        end
        regHit = seqHit || (|regSelect);
    end

    // ==========================================================
    // Configuration registers, each storing only its defined bits
    for (genvar g = 0; g < NREG; g++) begin : gCfg
        cfg_byte_reg #(
            .RESET_VALUE (REG_RESET[g]),
            .WRITE_MASK  (REG_MASK[g])
        ) uReg (
            .clk         (clk),
            .rstn        (rstn),
            .writeStrobe (regWrite && regSelect[g]),
            .writeData   (regWriteData),
            .value       (regValue[g])
        );
    end

    // Fixed address/value slots: plain byte storage
    for (genvar s = 0; s < FIXED_SEQ_BYTES; s++) begin : gSeq
        cfg_byte_reg #(
            .RESET_VALUE (FIXED_SEQ_RESET),
            .WRITE_MASK  (8'hFF)
        ) uSeq (
            .clk         (clk),
            .rstn        (rstn),
            .writeStrobe (regWrite && seqSelect[s]),
            .writeData   (regWriteData),
            .value       (seqValue[s])
        );
        assign fixedSeqBytes[8*s +: 8] = seqValue[s];
    end

    // ==========================================================
    // Read-back mux; unmapped addresses read as zero
    always_comb begin
        readMux = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (regSelect[i]) begin
                readMux = regValue[i];
            end
        end
        for (int j = 0; j < FIXED_SEQ_BYTES; j++) begin
            if (seqSelect[j]) begin
                readMux = seqValue[j];
            end
        end
        next_regReadData  = regRead ? readMux : regReadData;
        next_regReadValid = regRead;
    end

    // Registered read answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regReadData  <= 8'h00;
            regReadValid <= 1'b0;
        end else begin
            regReadData  <= next_regReadData;
            regReadValid <= next_regReadValid;
        end
    end

    // ==========================================================
    // Reference pin controls
    assign ref_pin_external_clock_select = regValue[0][REF_EXT_CLK_BIT];
    assign ref_oscillator_power_on       = regValue[0][REF_POWER_BIT];

    // ==========================================================
    // Loop mode decode; other codes are a host error and leave both off
    always_comb begin
        unique case (regValue[1][LOOP_MODE_LSB +: LOOP_MODE_W])
            LOOP_ZERO_DELAY: loopMode = LOOP_IS_ZERO_DELAY;
            LOOP_NORMAL:     loopMode = LOOP_IS_NORMAL;
            default:         loopMode = LOOP_IS_ILLEGAL;
        endcase
    end
    assign loop_mode_field = regValue[1][LOOP_MODE_LSB +: LOOP_MODE_W];
    assign zeroDelayMode   = (loopMode == LOOP_IS_ZERO_DELAY);
    assign normalMode      = (loopMode == LOOP_IS_NORMAL);
    assign loopModeIllegal = (loopMode == LOOP_IS_ILLEGAL);

    // ==========================================================
    // I/O level: resets to the core supply (1.8 V) option
    assign ioLevel3v3 = (regValue[2][IO_LEVEL_BIT] == IO_LEVEL_3V3);

    // ==========================================================
    // Input clock enables and routing
    assign inputEnables                    = regValue[3][IN_EN_LSB +: IN_EN_W];
    assign feedbackInputEnable             = regValue[3][IN_EN_LSB + 3];
    assign pulsed_single_ended_enables     = regValue[3][PULSED_LSB +: 4];
    assign input_to_phase_detector_enables = regValue[4][ROUTE_LSB +: ROUTE_W];
    assign feedbackRatioInteger            = regValue[5][0];

    // ==========================================================
    // Output divider clocking and interpolator bypass
    assign dividerClockEnables      = regValue[6][NUM_DIVIDERS-1:0];
    assign interpolator_bypass_bits = regValue[7][NUM_DIVIDERS-1:0];

endmodule // clock_gen_input_divider_config

// ===== clock_gen_input_divider_config_chk.sv
// Purpose: Port-level checker for the clock generator configuration bank.
// Assumes: One clock domain; outputs follow writes one cycle later.
// Notes:   Bound to every instance of the bank.
module clock_gen_input_divider_config_chk
    import clkgen_cfg_pkg::*;
#(
    parameter int NUM_DIVIDERS = 4
) (
    // Clock and reset
    input wire logic                              clk,
    input wire logic                              rstn,
    // Register port
    input wire logic [clkgen_cfg_pkg::ADDR_W-1:0] regAddr,
    input wire logic                              regWrite,
    input wire logic                              regRead,
    input wire logic [clkgen_cfg_pkg::DATA_W-1:0] regWriteData,
    input wire logic [clkgen_cfg_pkg::DATA_W-1:0] regReadData,
    input wire logic                              regReadValid,
    input wire logic                              regHit,
    // Decoded fields
    input wire logic                              ref_pin_external_clock_select,
    input wire logic                              ref_oscillator_power_on,
    input wire logic                              zeroDelayMode,
    input wire logic                              normalMode,
    input wire logic                              ioLevel3v3,
    input wire logic [3:0]                        inputEnables,
    input wire logic                              feedbackInputEnable,
    input wire logic [2:0]                        input_to_phase_detector_enables,
    input wire logic [NUM_DIVIDERS-1:0]           interpolator_bypass_bits
);
    // ==========================================================
    // Field and read port checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_REF_MODE: assert property (regWrite && regAddr == REFERENCE_PIN_CONFIG
        |=> ref_pin_external_clock_select == $past(regWriteData[0])) else $error("ref mode");
    AST_REF_POWER: assert property (regWrite && regAddr == REFERENCE_PIN_CONFIG
        |=> ref_oscillator_power_on == $past(regWriteData[1])) else $error("ref power");
    AST_LOOP_DECODE: assert property (regWrite && regAddr == LOOP_MODE_SELECT
        |=> zeroDelayMode == ($past(regWriteData[2:0]) == LOOP_ZERO_DELAY)
        && normalMode == ($past(regWriteData[2:0]) == LOOP_NORMAL)) else $error("loop decode");
    AST_IO_LEVEL: assert property (regWrite && regAddr == IO_LEVEL_CONFIG
        |=> ioLevel3v3 == $past(regWriteData[0])) else $error("io level");
    AST_IO_DEFAULT: assert property (!$past(rstn) |-> ioLevel3v3 == IO_LEVEL_1V8)
        else $error("io level default");
    AST_INPUT_EN: assert property (regWrite && regAddr == INPUT_CLOCK_CONTROL
        |=> inputEnables == $past(regWriteData[3:0]) && feedbackInputEnable == inputEnables[3])
        else $error("input enables");
    AST_ROUTE: assert property (regWrite && regAddr == INPUT_ROUTING_ENABLE
        |=> input_to_phase_detector_enables == $past(regWriteData[6:4])) else $error("route");
    AST_BYPASS: assert property (regWrite && regAddr == DIVIDER_INTERP_BYPASS
        |=> interpolator_bypass_bits == $past(regWriteData[3:0])) else $error("bypass");
    AST_READBACK: assert property (regRead && !regWrite && regAddr == DIVIDER_INTERP_BYPASS
        |=> regReadValid && regReadData == {4'h0, interpolator_bypass_bits})
        else $error("readback");
    AST_UNMAPPED: assert property (regRead && !regHit |=> regReadValid && regReadData == 8'h00)
        else $error("unmapped read");
    AST_HOLD: assert property (!regWrite |=> $stable(inputEnables)) else $error("hold");
endmodule // clock_gen_input_divider_config_chk

bind clock_gen_input_divider_config clock_gen_input_divider_config_chk #(
    .NUM_DIVIDERS(NUM_DIVIDERS)) u_clock_gen_input_divider_config_chk (.clk, .rstn, .regAddr,
    .regWrite, .regRead, .regWriteData, .regReadData, .regReadValid, .regHit,
    .ref_pin_external_clock_select, .ref_oscillator_power_on, .zeroDelayMode, .normalMode,
    .ioLevel3v3, .inputEnables, .feedbackInputEnable, .input_to_phase_detector_enables,
    .interpolator_bypass_bits);

// ===== clock_gen_input_divider_config_tb.sv
// Purpose: Self-checking bench for the clock generator configuration bank.
// Assumes: Byte accesses with one-cycle registered read data.
// Notes:   Host only writes legal loop codes.
module clock_gen_input_divider_config_tb;
    import clkgen_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals
    logic        clk, rstn, regWrite, regRead, regReadValid, regHit;
    logic [15:0] regAddr;
    logic [7:0]  regWriteData, regReadData;
    logic        refExt, refPwr, zeroDelayMode, normalMode, loopModeIllegal, ioLevel3v3;
    logic        feedbackInputEnable, feedbackRatioInteger;
    logic [3:0]  inputEnables, pulsedEn, divEn, bypass;
    logic [2:0]  loopField, route;
    logic [95:0] fixedSeqBytes;
    int          mismatches, numChecks;
    localparam logic [15:0] ADR [7] = '{REFERENCE_PIN_CONFIG, IO_LEVEL_CONFIG,
        INPUT_CLOCK_CONTROL, INPUT_ROUTING_ENABLE, FEEDBACK_RATIO_FLAG,
        DIVIDER_CLOCK_ENABLE, DIVIDER_INTERP_BYPASS};
    localparam logic [7:0] MSK [7] = '{8'h03, 8'h01, 8'hFF, 8'h70, 8'h01, 8'h0F, 8'h0F};
    localparam logic [7:0] RST [7] = '{REF_CFG_RESET, IO_LEVEL_RESET, IN_CTRL_RESET,
        ROUTE_RESET, RATIO_RESET, DIV_EN_RESET, DIV_BYP_RESET};

    // Design under test
    clock_gen_input_divider_config #(.NUM_DIVIDERS(4)) u_clock_gen_input_divider_config (
        .clk, .rstn, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData,
        .regReadValid, .regHit, .ref_pin_external_clock_select(refExt),
        .ref_oscillator_power_on(refPwr), .loop_mode_field(loopField), .zeroDelayMode,
        .normalMode, .loopModeIllegal, .ioLevel3v3, .inputEnables, .feedbackInputEnable,
        .pulsed_single_ended_enables(pulsedEn), .input_to_phase_detector_enables(route),
        .feedbackRatioInteger, .dividerClockEnables(divEn), .interpolator_bypass_bits(bypass),
        .fixedSeqBytes);

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // One access: entered and left just after a rising edge
    task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r,
                       input logic [7:0] e, input string n);
        int i;
        regAddr <= a;
        regWriteData <= d;
        regWrite <= w;
        regRead <= r;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
        for (i = 0; r && regReadValid !== 1'b1; i++) begin
            if (i == 4) begin
                mismatches++;
                final_report();
            end
            @(posedge clk);
            #1;
        end
        if (r) check(n, regReadData, e);
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(a, d, 1'b1, 1'b0, 8'h00, "");
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
        acc(a, 8'h00, 1'b0, 1'b1, e, n);
    endtask

    task automatic resetChk();
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("ioLevel3v3", ioLevel3v3, IO_LEVEL_1V8);
        check("normalMode", normalMode, 1'b1);
        for (int k = 0; k < 7; k++) rd(ADR[k], RST[k], "resetValue");
        rd(LOOP_MODE_SELECT, LOOP_MODE_RESET, "loopReset");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rstn, regWrite, regRead, regAddr, regWriteData} = '0;
        @(posedge clk);
        resetChk();
        for (int k = 0; k < 7; k++) begin
            wr(ADR[k], 8'hFF);
            rd(ADR[k], MSK[k], "maskedOnes");
            wr(ADR[k], 8'h00);
            rd(ADR[k], 8'h00, "cleared");
        end
        wr(REFERENCE_PIN_CONFIG, 8'h01);
        check("refExt", refExt, 1'b1);
        check("refPwr", refPwr, 1'b0);
        wr(REFERENCE_PIN_CONFIG, 8'h02);
        check("refExt", refExt, 1'b0);
        check("refPwr", refPwr, 1'b1);
        for (int c = 3; c <= 4; c++) begin
            wr(LOOP_MODE_SELECT, 8'(c));
            check("zeroDelay", zeroDelayMode, 1'(c == 3));
            check("normal", normalMode, 1'(c == 4));
            check("loopField", loopField, 8'(c));
            check("loopIllegal", loopModeIllegal, 1'b0);
            rd(LOOP_MODE_SELECT, 8'(c), "loopCode");
        end
        wr(IO_LEVEL_CONFIG, 8'h01);
        check("ioLevel3v3", ioLevel3v3, IO_LEVEL_3V3);
        for (int i = 0; i < 4; i++) begin
            wr(INPUT_CLOCK_CONTROL, 8'h01 << i);
            check("inputEnables", inputEnables, 8'h01 << i);
            check("feedbackIn", feedbackInputEnable, 1'(i == 3));
            wr(DIVIDER_CLOCK_ENABLE, 8'h01 << i);
            check("divEn", divEn, 8'h01 << i);
            wr(DIVIDER_INTERP_BYPASS, 8'h01 << i);
            check("bypass", bypass, 8'h01 << i);
            if (i < 3) wr(INPUT_ROUTING_ENABLE, 8'h10 << i);
            if (i < 3) check("route", route, 8'h01 << i);
        end
        wr(INPUT_CLOCK_CONTROL, 8'hF0);
        check("pulsedEn", pulsedEn, 8'h0F);
        wr(FEEDBACK_RATIO_FLAG, 8'h01);
        check("ratioFlag", feedbackRatioInteger, 1'b1);
        for (int k = 0; k < 12; k++) wr(16'(FIXED_SEQ_BASE + k), 8'(8'h11 * (k + 1)));
        for (int k = 0; k < 12; k++) begin
            rd(16'(FIXED_SEQ_BASE + k), 8'(8'h11 * (k + 1)), "fixedRead");
            check("fixedOut", fixedSeqBytes[8*k+:8], 8'(8'h11 * (k + 1)));
        end
        wr(16'h0862, 8'h5A);
        rd(16'h0862, 8'h00, "unmapped");
        check("regHit", regHit, 1'b0);
        rd(FIXED_SEQ_LAST, 8'hCC, "noAlias");
        check("regHitSeq", regHit, 1'b1);
        // Divider power and clock-disable fields live outside this bank
        rd(16'h0A05, 8'h00, "powerFieldOutside");
        rd(16'h0B4A, 8'h00, "clkDisFieldOutside");
        acc(DIVIDER_CLOCK_ENABLE, 8'h05, 1'b1, 1'b1, 8'h08, "oldValue");
        rd(DIVIDER_CLOCK_ENABLE, 8'h05, "newValue");
        resetChk();
        final_report();
    end
endmodule // clock_gen_input_divider_config_tb
